/* rtl/rise_pkg.sv */
// Constants, register map and types of the radio interrupt and status block
package rise_pkg;

    // Register addresses on the serial port
    localparam logic [6:0] ADDR_STATUS_ONE = 7'h03;
    localparam logic [6:0] ADDR_STATUS_TWO = 7'h04;
    localparam logic [6:0] ADDR_IRQ_EN_ONE = 7'h05;
    localparam logic [6:0] ADDR_IRQ_EN_TWO = 7'h06;

    // Reset values of the enable registers, and the value read at unmapped addresses
    localparam logic [7:0] IRQ_EN_ONE_RESET = 8'h00;
    localparam logic [7:0] IRQ_EN_TWO_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Group one bit positions (enable and status share them)
    localparam int BIT_FIFO_ERR = 7;
    localparam int BIT_TXF_AFULL = 6;
    localparam int BIT_TXF_AEMPTY = 5;
    localparam int BIT_RXF_AFULL = 4;
    localparam int BIT_EXT = 3;
    localparam int BIT_PKT_SENT = 2;
    localparam int BIT_PKT_VALID = 1;
    localparam int BIT_CRC_ERR = 0;

    // Group two bit positions
    localparam int BIT_SYNC_DET = 7;
    localparam int BIT_PRE_VALID = 6;
    localparam int BIT_PRE_INVALID = 5;
    localparam int BIT_RSSI = 4;
    localparam int BIT_WAKE_TIMER = 3;
    localparam int BIT_LOW_BATT = 2;
    localparam int BIT_CHIP_READY = 1;
    localparam int BIT_POWER_ON = 0;

    // Serial frame layout: R/W flag then seven address bits, MSB first
    localparam int SPI_RW_BIT = 7;
    localparam logic [3:0] SPI_LAST_ADDR_BIT = 4'h7;
    localparam logic [3:0] SPI_LAST_DATA_BIT = 4'hF;
    localparam logic [3:0] SPI_FIRST_DATA_BIT = 4'h8;

    // Timing
    localparam int CLOCK_MHZ = 50;
    localparam int XTAL_SETTLE_US = 600;
    localparam int XTAL_SETTLE_CYCLES = XTAL_SETTLE_US * CLOCK_MHZ;

    typedef enum logic [2:0] {
        SPI_IDLE = 3'b001,
        SPI_ADDR = 3'b010,
        SPI_DATA = 3'b100
    } rise_spi_state_t;

endpackage

/* rtl/rise_spi_port.sv */
// Serial register port: mode 0 slave, one address byte, burst data bytes
`timescale 1ns/1ps
`default_nettype none
module rise_spi_port (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Pins from the host
    input wire logic sclk,
    input wire logic ssel_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Register side
    output logic wr_req,
    output logic rd_req,
    output logic [6:0] reg_addr,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    logic [2:0] sclk_sync;
    logic [1:0] ssel_sync;
    logic [1:0] sdi_sync;
    rise_pkg::rise_spi_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] in_sh;
    logic [7:0] out_sh;
    logic is_write;

    // Host must keep sclk below one eighth of clock for the sync delay
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync <= 3'h0;
            ssel_sync <= 2'h3;
            sdi_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk};
            ssel_sync <= {ssel_sync[0], ssel_n};
            sdi_sync <= {sdi_sync[0], sdi};
        end
    end

    wire selected = !ssel_sync[1];
    wire sclk_rise = sclk_sync[1] && !sclk_sync[2];
    wire sclk_fall = !sclk_sync[1] && sclk_sync[2];
    wire [7:0] in_byte = {in_sh[6:0], sdi_sync[1]};
    wire byte_done = sclk_rise && (bit_cnt == rise_pkg::SPI_LAST_ADDR_BIT
        || bit_cnt == rise_pkg::SPI_LAST_DATA_BIT);
    wire [6:0] next_addr = reg_addr + 7'h01;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= rise_pkg::SPI_IDLE;
            bit_cnt <= 4'h0;
            in_sh <= 8'h00;
            is_write <= 1'b0;
            reg_addr <= 7'h00;
            wr_data <= 8'h00;
            wr_req <= 1'b0;
            rd_req <= 1'b0;
        end else begin
            wr_req <= 1'b0;
            rd_req <= 1'b0;
            // Write pulses carry the address of the byte just ended,
            // so a write burst moves on only after the pulse
            if (wr_req) begin
                reg_addr <= next_addr;
            end
            if (!selected) begin
                state <= rise_pkg::SPI_IDLE;
                bit_cnt <= 4'h0;
            end else if (sclk_rise) begin
                in_sh <= in_byte;
                bit_cnt <= byte_done ? rise_pkg::SPI_FIRST_DATA_BIT
                                     : bit_cnt + 4'h1;
                unique case (state)
                    rise_pkg::SPI_IDLE, rise_pkg::SPI_ADDR: begin
                        state <= byte_done ? rise_pkg::SPI_DATA
                                           : rise_pkg::SPI_ADDR;
                        if (byte_done) begin
                            is_write <= in_byte[rise_pkg::SPI_RW_BIT];
                            reg_addr <= in_byte[6:0];
                            rd_req <= !in_byte[rise_pkg::SPI_RW_BIT];
                        end
                    end
                    rise_pkg::SPI_DATA: begin
                        if (byte_done) begin
                            if (!is_write) begin
                                reg_addr <= next_addr;
                            end
                            wr_req <= is_write;
                            wr_data <= in_byte;
                            rd_req <= !is_write;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_sh <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= selected && state == rise_pkg::SPI_DATA && !is_write;
            if (rd_req) begin
                out_sh <= rd_data;
            end else if (sclk_fall && state == rise_pkg::SPI_DATA) begin
                sdo <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

endmodule // rise_spi_port
`default_nettype wire

/* rtl/rise_irq_status.sv */
// Interrupt status groups, enable registers and interrupt pin
`timescale 1ns/1ps
`default_nettype none
module rise_irq_status #(
    parameter int SETTLE_CYCLES = rise_pkg::XTAL_SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Serial register port
    input wire logic sclk,
    input wire logic ssel_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Interrupt pin
    output logic irq_out_low,
    // Group one levels from the FIFO and packet engine
    input wire logic fifo_err,
    input wire logic txf_afull,
    input wire logic txf_aempty,
    input wire logic rxf_afull,
    input wire logic ext_irq,
    input wire logic pkt_sent,
    input wire logic pkt_valid,
    input wire logic crc_error,
    // Group two events from the receiver and supervisors
    input wire logic sync_found,
    input wire logic rx_packet_done,
    input wire logic preamble_found,
    input wire logic sync_timeout,
    input wire logic preamble_invalid,
    input wire logic rssi_above,
    input wire logic wake_timer_expired,
    input wire logic low_batt_event,
    input wire logic power_on_event,
    // Operating mode
    input wire logic xtal_on,
    input wire logic tx_on,
    input wire logic rx_on,
    input wire logic idle_state
);
    logic wr_req;
    logic rd_req;
    logic [6:0] reg_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] irq_enable_group_one;
    logic [7:0] irq_enable_group_two;
    logic [7:0] stat_one;
    logic [7:0] stat_two;
    logic [7:0] cond_one_prev;
    logic [7:0] cond_two_prev;
    logic sync_det_state;
    logic pre_valid_state;
    logic low_batt_hold;
    logic chip_ready;
    logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_cnt;

    // Enabled bits latch rises and clear on read; set beats a same-cycle
    // clear so no event is lost. Unenabled bits mirror their source.
    function automatic logic [7:0] next_stat(input logic [7:0] stat,
        input logic [7:0] en, input logic [7:0] cond,
        input logic [7:0] prev, input logic rd);
        logic [7:0] rise;
        rise = cond & ~prev;
        return (en & ((stat & ~{8{rd}}) | rise)) | (~en & cond);
    endfunction

    rise_spi_port u_spi (
        .clock(clock),
        .reset_n(reset_n),
        .sclk(sclk),
        .ssel_n(ssel_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .wr_req(wr_req),
        .rd_req(rd_req),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    // Register decode
    wire rd_one = rd_req && reg_addr == rise_pkg::ADDR_STATUS_ONE;
    wire rd_two = rd_req && reg_addr == rise_pkg::ADDR_STATUS_TWO;
    wire wr_en_one = wr_req && reg_addr == rise_pkg::ADDR_IRQ_EN_ONE;
    wire wr_en_two = wr_req && reg_addr == rise_pkg::ADDR_IRQ_EN_TWO;

    // The pin looks at the next enables, so unmasking a held flag pulls
    // it low on the same edge that the enable lands
    wire [7:0] next_en_one = wr_en_one ? wr_data : irq_enable_group_one;
    wire [7:0] next_en_two = wr_en_two ? wr_data : irq_enable_group_two;

    assign rd_data =
        (reg_addr == rise_pkg::ADDR_STATUS_ONE) ? stat_one :
        (reg_addr == rise_pkg::ADDR_STATUS_TWO) ? stat_two :
        (reg_addr == rise_pkg::ADDR_IRQ_EN_ONE) ? irq_enable_group_one :
        (reg_addr == rise_pkg::ADDR_IRQ_EN_TWO) ? irq_enable_group_two :
        rise_pkg::UNMAPPED_READ;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_enable_group_one <= rise_pkg::IRQ_EN_ONE_RESET;
            irq_enable_group_two <= rise_pkg::IRQ_EN_TWO_RESET;
        end else begin
            if (wr_en_one) begin
                irq_enable_group_one <= wr_data;
            end
            if (wr_en_two) begin
                irq_enable_group_two <= wr_data;
            end
        end
    end

    // Group one sources, positioned by enable bit
    wire [7:0] cond_one = {fifo_err, txf_afull, txf_aempty, rxf_afull,
        ext_irq, pkt_sent, pkt_valid, crc_error};

    // Sync and preamble trackers; a set in the same cycle as a clear wins
    wire next_sync_det = sync_found || (sync_det_state && !rx_packet_done);
    wire next_pre_valid = preamble_found
        || (pre_valid_state && !(sync_found || sync_timeout));

    // Low battery is held until a read clears it while enabled
    wire lbd_read_clear =
        rd_two && irq_enable_group_two[rise_pkg::BIT_LOW_BATT];
    wire next_low_batt = low_batt_event
        || (low_batt_hold && !lbd_read_clear);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_det_state <= 1'b0;
            pre_valid_state <= 1'b0;
            low_batt_hold <= 1'b0;
        end else begin
            sync_det_state <= next_sync_det;
            pre_valid_state <= next_pre_valid;
            low_batt_hold <= next_low_batt;
        end
    end

    // Module ready: settle counter restarts whenever nothing is enabled
    wire osc_wanted = (xtal_on || tx_on || rx_on) && !idle_state;
    wire settle_done = settle_cnt == ($bits(settle_cnt))'(SETTLE_CYCLES);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            settle_cnt <= '0;
            chip_ready <= 1'b0;
        end else if (!osc_wanted) begin
            settle_cnt <= '0;
            chip_ready <= 1'b0;
        end else if (!settle_done) begin
            settle_cnt <= settle_cnt + 1'b1;
        end else begin
            chip_ready <= 1'b1;
        end
    end

    // Invalid preamble, wake timer and power-on are single-cycle events,
    // so their plain status clears itself
    wire [7:0] cond_two = {sync_det_state, pre_valid_state,
        preamble_invalid, rssi_above, wake_timer_expired,
        low_batt_hold, chip_ready, power_on_event};

    wire [7:0] next_stat_one = next_stat(stat_one, irq_enable_group_one,
        cond_one, cond_one_prev, rd_one);
    wire [7:0] next_stat_two = next_stat(stat_two, irq_enable_group_two,
        cond_two, cond_two_prev, rd_two);

    wire [7:0] pend_one = next_stat_one & next_en_one;
    wire [7:0] pend_two = next_stat_two & next_en_two;
    wire next_irq_out_low = !(|pend_one || |pend_two);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stat_one <= 8'h00;
            stat_two <= 8'h00;
            cond_one_prev <= 8'h00;
            cond_two_prev <= 8'h00;
            irq_out_low <= 1'b1;
        end else begin
            stat_one <= next_stat_one;
            stat_two <= next_stat_two;
            cond_one_prev <= cond_one;
            cond_two_prev <= cond_two;
            irq_out_low <= next_irq_out_low;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    wire [7:0] en_two = irq_enable_group_two;
    wire pending = |(stat_one & irq_enable_group_one)
        || |(stat_two & irq_enable_group_two);

    a_irq_pending: assert property (pending |-> !irq_out_low)
        else $error("interrupt pin high with an enabled flag pending");

    a_irq_idle_high: assert property (
        !pending |-> irq_out_low)
        else $error("interrupt pin low with nothing pending");

    a_read_clears: assert property (
        rd_two && (cond_two & ~cond_two_prev) == 8'h00 && !low_batt_event
        |=> (stat_two & $past(en_two)) == 8'h00)
        else $error("enabled status bit survived a status read");

    a_plain_status: assert property (
        1'b1 |=> (stat_two & ~$past(en_two))
            == ($past(cond_two) & ~$past(en_two)))
        else $error("unenabled status bit does not follow its source");

    a_one_plain: assert property (
        1'b1 |=> (stat_one & ~$past(irq_enable_group_one))
            == ($past(cond_one) & ~$past(irq_enable_group_one)))
        else $error("unenabled group one bit does not follow its source");

    a_one_read_clears: assert property (
        rd_one && (cond_one & ~cond_one_prev) == 8'h00
        |=> (stat_one & $past(irq_enable_group_one)) == 8'h00)
        else $error("enabled group one bit survived a status read");

    a_en_one_write: assert property (
        wr_en_one |=> irq_enable_group_one == $past(wr_data))
        else $error("enable one write did not land");

    a_one_rise_irq: assert property (
        (cond_one & ~cond_one_prev & irq_enable_group_one) != 8'h00
        && !wr_en_one |=> !irq_out_low)
        else $error("enabled group one rise did not pull the pin low");

    a_two_rise_irq: assert property (
        (cond_two & ~cond_two_prev & en_two) != 8'h00
        && !wr_en_two |=> !irq_out_low)
        else $error("enabled group two rise did not pull the pin low");

    a_sync_set: assert property (
        sync_found && !sync_det_state
        |=> sync_det_state ##1 stat_two[rise_pkg::BIT_SYNC_DET])
        else $error("sync flag not raised after sync found");

    a_sync_clear: assert property (
        rx_packet_done && !sync_found |=> !sync_det_state)
        else $error("sync flag not cleared at end of packet");

    a_preamble_clear: assert property (
        (sync_found || sync_timeout) && !preamble_found
        |=> !pre_valid_state)
        else $error("preamble flag not cleared by sync or timeout");

    a_invalid_self: assert property (
        !en_two[rise_pkg::BIT_PRE_INVALID] && !preamble_invalid
        |=> !stat_two[rise_pkg::BIT_PRE_INVALID])
        else $error("invalid preamble status did not clear itself");

    a_rssi_level: assert property (
        !en_two[rise_pkg::BIT_RSSI]
        |=> stat_two[rise_pkg::BIT_RSSI] == $past(rssi_above))
        else $error("signal strength status does not track comparator");

    a_lbd_saved: assert property (
        low_batt_event && !en_two[rise_pkg::BIT_LOW_BATT]
        ##1 !en_two[rise_pkg::BIT_LOW_BATT]
        |=> stat_two[rise_pkg::BIT_LOW_BATT])
        else $error("masked low battery event was not saved");

    a_lbd_hold: assert property (
        low_batt_hold && !lbd_read_clear |=> low_batt_hold)
        else $error("saved low battery flag was lost");

    a_lbd_later_irq: assert property (
        low_batt_hold && $rose(en_two[rise_pkg::BIT_LOW_BATT])
        && !lbd_read_clear |=> !irq_out_low)
        else $error("saved low battery did not interrupt when enabled");

    a_ready_settle: assert property (
        $rose(chip_ready) |-> $past(settle_done) && $past(osc_wanted))
        else $error("module ready raised before crystal settled");

    a_ready_hold: assert property (
        chip_ready && osc_wanted |=> chip_ready)
        else $error("module ready dropped before returning to idle");

    a_ready_idle: assert property (
        idle_state |=> !chip_ready)
        else $error("module ready still high in idle");

    a_group_one_mask: assert property (
        irq_enable_group_one == 8'h00 && irq_enable_group_two == 8'h00
        ##1 irq_enable_group_one == 8'h00 && irq_enable_group_two == 8'h00
        |-> irq_out_low)
        else $error("interrupt with every enable bit cleared");

    c_irq_raised: cover property ($fell(irq_out_low));
    c_status_read: cover property (rd_two && pending ##2 !pending);
    c_ready_rise: cover property ($rose(chip_ready));
    c_lbd_late: cover property (
        low_batt_hold && $rose(en_two[rise_pkg::BIT_LOW_BATT]));
    c_group_one_read: cover property (rd_one && pending ##2 !pending);

endmodule // rise_irq_status
`default_nettype wire

/* testbench/rise_host_model.sv */
// Host microcontroller model: serial master for the register port
`timescale 1ns/1ps
`default_nettype none
module rise_host_model (
    // Clock
    input wire logic clock,
    // Serial pins
    output logic sclk,
    output logic ssel_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    initial begin
        sclk = 1'b0;
        ssel_n = 1'b1;
        sdi = 1'b0;
    end

    // Six clocks per phase leaves margin over the four-clock minimum
    task automatic half_bit();
        repeat (6) @(posedge clock);
        #1;
    endtask

    // One address byte then one data byte, sampled on each sclk rise
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [15:0] sh;
        sh = {cmd, wd};
        rdat = 8'h00;
        @(posedge clock);
        #1;
        ssel_n = 1'b0;
        half_bit();
        for (int i = 15; i >= 0; i--) begin
            sdi = sh[i];
            half_bit();
            sclk = 1'b1;
            // An undriven line reads as the inverse of its last level
            if (i < 8) rdat = {rdat[6:0], sdo_oe ? sdo : ~sdo};
            half_bit();
            sclk = 1'b0;
        end
        half_bit();
        ssel_n = 1'b1;
        sdi = ~sdi;
        half_bit();
    endtask
endmodule // rise_host_model
`default_nettype wire

/* testbench/tb.sv */
// Self-checking testbench of the radio interrupt and status block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int SETTLE = 300;
    logic clock, reset_n, sclk, ssel_n, sdi, sdo, sdo_oe, irq_out_low;
    logic [7:0] g1, ev2;
    logic rx_done, sync_to, rssi, xtal, tx_on, rx_on, idle;
    int error_cnt, n_checks;

    rise_irq_status #(.SETTLE_CYCLES(SETTLE)) i_dut (
        .clock(clock), .reset_n(reset_n), .sclk(sclk), .ssel_n(ssel_n),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .irq_out_low(irq_out_low),
        .fifo_err(g1[7]), .txf_afull(g1[6]), .txf_aempty(g1[5]),
        .rxf_afull(g1[4]), .ext_irq(g1[3]), .pkt_sent(g1[2]),
        .pkt_valid(g1[1]), .crc_error(g1[0]), .sync_found(ev2[7]),
        .rx_packet_done(rx_done), .preamble_found(ev2[6]),
        .sync_timeout(sync_to), .preamble_invalid(ev2[5]),
        .rssi_above(rssi), .wake_timer_expired(ev2[3]),
        .low_batt_event(ev2[2]), .power_on_event(ev2[0]),
        .xtal_on(xtal), .tx_on(tx_on), .rx_on(rx_on), .idle_state(idle)
    );

    rise_host_model i_host (
        .clock(clock), .sclk(sclk), .ssel_n(ssel_n), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        i_host.xfer({1'b1, a}, d, r);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] r;
        i_host.xfer({1'b0, a}, 8'h00, r);
        chk($sformatf("reg %h", a), exp, r);
    endtask

    task automatic pin(input logic exp);
        chk("irq_out_low", {7'h00, exp}, {7'h00, irq_out_low});
    endtask

    task automatic pulse2(input int b);
        ev2[b] = 1'b1;
        step(1);
        ev2 = 8'h00;
        step(3);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        finish_test();
    end

    initial begin
        error_cnt = 0;
        n_checks = 0;
        reset_n = 1'b0;
        g1 = 8'h00;
        ev2 = 8'h00;
        {rx_done, sync_to, rssi, xtal, tx_on, rx_on} = 6'h00;
        idle = 1'b1;
        step(5);
        reset_n = 1'b1;
        step(4);
        pin(1'b1);
        rd(rise_pkg::ADDR_IRQ_EN_ONE, rise_pkg::IRQ_EN_ONE_RESET);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h00);
        wr(rise_pkg::ADDR_IRQ_EN_ONE, 8'hA5);
        rd(rise_pkg::ADDR_IRQ_EN_ONE, 8'hA5);
        wr(rise_pkg::ADDR_IRQ_EN_ONE, 8'h5A);
        rd(rise_pkg::ADDR_IRQ_EN_ONE, 8'h5A);
        rd(7'h10, rise_pkg::UNMAPPED_READ);
        wr(rise_pkg::ADDR_STATUS_TWO, 8'hFF);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h00);
        // Each enable bit alone; a neighbour source stays plain status
        for (int i = 0; i < 8; i++) begin
            wr(rise_pkg::ADDR_IRQ_EN_ONE, 8'h01 << i);
            g1 = (8'h01 << i) | (8'h01 << ((i + 1) % 8));
            step(3);
            pin(1'b0);
            rd(rise_pkg::ADDR_STATUS_ONE, g1);
            pin(1'b1);
            rd(rise_pkg::ADDR_STATUS_ONE, 8'h01 << ((i + 1) % 8));
            g1 = 8'h00;
        end
        wr(rise_pkg::ADDR_IRQ_EN_ONE, 8'h00);
        // Sync and preamble flags as plain status
        pulse2(6);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h40);
        pulse2(7);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h80);
        rx_done = 1'b1;
        step(1);
        rx_done = 1'b0;
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h00);
        pulse2(6);
        sync_to = 1'b1;
        step(1);
        sync_to = 1'b0;
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h00);
        rssi = 1'b1;
        step(3);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h10);
        rssi = 1'b0;
        step(3);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h00);
        // Ready only after settling, gone again in idle
        idle = 1'b0;
        xtal = 1'b1;
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h00);
        step(SETTLE);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h02);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h02);
        idle = 1'b1;
        step(3);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h00);
        xtal = 1'b0;
        // Low battery saved while masked, interrupts once enabled
        pulse2(2);
        pin(1'b1);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h04);
        wr(rise_pkg::ADDR_IRQ_EN_TWO, 8'h04);
        step(3);
        pin(1'b0);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h04);
        pin(1'b1);
        rd(rise_pkg::ADDR_STATUS_TWO, 8'h00);
        // Event flags taken as interrupts, each enable bit alone, then read back
        foreach (ev2[b]) begin
            if (b inside {7, 6, 5, 3, 0}) begin
                wr(rise_pkg::ADDR_IRQ_EN_TWO, 8'h01 << b);
                pulse2(b);
                pin(1'b0);
                rd(rise_pkg::ADDR_STATUS_TWO, 8'h01 << b);
                pin(1'b1);
                {rx_done, sync_to} = 2'b11;
                step(1);
                {rx_done, sync_to} = 2'b00;
            end
        end
        finish_test();
    end
endmodule // tb
`default_nettype wire
